// ---- tb/amp_protect_assertions.sv ----
// Concurrent checks on the protection supervisor ports
`timescale 1ns/1ps
module amp_protect_assertions (
   // Clock, reset and bus
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   // Pins and sense
   input wire logic reset_pin_n,
   input wire logic [1:0] mode_pins,
   input wire amp_protect_pkg::sense_type sense,
   // Watched outputs
   input wire logic fault_n_out,
   input wire logic fault_n_oe,
   input wire logic clip_temp_warn_n,
   input wire logic clip_temp_warn_oe,
   input wire logic [3:0] hb_enable,
   input wire logic [3:0] inject_pulse,
   input wire logic [1:0] oc_threshold,
   input wire logic oc_latched
);
   import amp_protect_pkg::*;
   // Cycles since bus reset release, saturating
   logic [11:0] since;
   // Set once a half-bridge switched, so the startup check is over
   logic seen_done;
   // Helper state, cleared with the bus reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         since <= 12'h000;
         seen_done <= 1'b0;
      end else begin
         since <= (since == 12'hfff) ? since : since + 12'h001;
         seen_done <= seen_done | (|hb_enable);
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Address phase of a write to the control word
   sequence s_wr_ctrl;
      hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h00;
   endsequence
   // Die hot, then cooled, reset pin released throughout
   sequence s_hot;
      (sense.temp_shut && reset_pin_n) [*5];
   endsequence
   sequence s_cool;
      (!sense.temp_shut && reset_pin_n) [*5];
   endsequence
   a_pins_open_drain: assert property (fault_n_out == 1'b0 && clip_temp_warn_n == 1'b0)
      else $error("status pin driven high");
   a_warn_level: assert property (sense.temp_warn [*5] |-> clip_temp_warn_oe)
      else $error("warning not pulled low");
   a_uv_shut: assert property ((sense.undervolt && reset_pin_n) [*5] |-> fault_n_oe && hb_enable == 4'h0)
      else $error("undervoltage not shut down");
   a_reset_release: assert property ((!reset_pin_n && seen_done) [*5] |-> !fault_n_oe && hb_enable == 4'h0)
      else $error("fault not released in reset");
   a_therm_shut: assert property (s_hot |-> fault_n_oe && hb_enable == 4'h0)
      else $error("thermal shutdown missing");
   a_therm_hold: assert property (s_hot ##1 s_cool |-> fault_n_oe && hb_enable == 4'h0)
      else $error("thermal latch lost");
   a_check_hold: assert property (since > 12'h003 && since < 12'hf3c && !mode_pins[0] |-> fault_n_oe && !hb_enable)
      else $error("startup check not holding");
   a_inject_once: assert property (|inject_pulse |=> inject_pulse == 4'h0)
      else $error("inject pulse too long");
   a_sel_invalid: assert property (s_wr_ctrl ##1 hwdata[3] |-> ##2 oc_threshold == 2'h3 && !oc_latched)
      else $error("invalid select not minimum");
   a_sel_valid: assert property (s_wr_ctrl ##1 !hwdata[3] |-> ##2 {oc_latched, oc_threshold} == $past(hwdata[2:0], 2))
      else $error("select not applied");
   a_latch_oc: assert property (oc_latched && reset_pin_n && $rose(sense.overcurrent[2]) |->
      ##[2:8] (hb_enable[3:2] == 2'b00 && fault_n_oe))
      else $error("latched overcurrent not shut");
endmodule
bind amp_protect amp_protect_assertions chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .reset_pin_n(reset_pin_n),
   .mode_pins(mode_pins), .sense(sense), .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe),
   .clip_temp_warn_n(clip_temp_warn_n), .clip_temp_warn_oe(clip_temp_warn_oe), .hb_enable(hb_enable),
   .inject_pulse(inject_pulse), .oc_threshold(oc_threshold), .oc_latched(oc_latched));

// ---- tb/mcu_model.sv ----
// Behavioural system controller: watches status pins, drives reset pin
`timescale 1ns/1ps
module mcu_model #(
   // Default is 4 ms of the 20 MHz clock
   parameter int HOLD_CYC = 80000
) (
   // Clock
   input wire logic clk,
   // Status pin levels
   input wire logic fault_pin,
   input wire logic warn_pin,
   // Bench asks for reset
   input wire logic rst_req,
   // Controller outputs
   output logic reset_pin_n,
   output logic vol_down
);
   // Cycles since fault fell, saturating at the hold
   int since = HOLD_CYC;
   // Last fault pin level
   logic fault_q = 1'b1;
   initial reset_pin_n = 1'b1;
   initial vol_down = 1'b0;
   // Release waits out the hold, protecting a hot die after a fault
   always @(posedge clk) begin
      fault_q <= fault_pin;
      since <= (fault_q && !fault_pin) ? 0 : (since < HOLD_CYC) ? since + 1 : since;
      if (rst_req) begin
         reset_pin_n <= 1'b0;
      end else if (since >= HOLD_CYC) begin
         reset_pin_n <= 1'b1;
      end
      vol_down <= !warn_pin;
   end
endmodule

// ---- tb/tb_amp_protection_fault_reporting.sv ----
// Self-checking bench for the protection supervisor
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module tb_amp_protection_fault_reporting;
   import amp_protect_pkg::*;
   // Shortened reset hold keeps the run brief; a real controller waits 4 ms
   localparam int HOLD = 40;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   // Bus master side
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, hready;
   // Device side
   logic [1:0] mode_pins = 2'h0;
   sense_type sense = '0;
   logic rst_req = 1'b0;
   logic reset_pin_n, vol_down, fault_n_out, fault_n_oe, clip_temp_warn_n, clip_temp_warn_oe, oc_latched;
   logic [3:0] hb_enable, flip_state, inject_pulse;
   logic [1:0] oc_threshold;
   // Counters and the counter model of half A
   int n_errors = 0;
   int checks = 0;
   int seed = 14;
   int cyc_cnt = 0;
   int n_inj = 0;
   int m_cnt = 0;
   int m_ev = 0;
   // Pulled-up pin levels
   wire fault_pin = fault_n_oe ? fault_n_out : 1'b1;
   wire warn_pin = clip_temp_warn_oe ? clip_temp_warn_n : 1'b1;
   assign hready = hreadyout;
   amp_protect dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .reset_pin_n(reset_pin_n), .mode_pins(mode_pins), .sense(sense), .fault_n_out(fault_n_out),
      .fault_n_oe(fault_n_oe), .clip_temp_warn_n(clip_temp_warn_n), .clip_temp_warn_oe(clip_temp_warn_oe),
      .hb_enable(hb_enable), .flip_state(flip_state), .inject_pulse(inject_pulse), .oc_threshold(oc_threshold),
      .oc_latched(oc_latched));
   mcu_model #(.HOLD_CYC(HOLD)) mcu_u (.clk(hclk), .fault_pin(fault_pin), .warn_pin(warn_pin),
      .rst_req(rst_req), .reset_pin_n(reset_pin_n), .vol_down(vol_down));
   initial begin
      forever #25 hclk = ~hclk;
   end
   // Timeout and count of injected pulses on half A
   always @(posedge hclk) begin
      cyc_cnt++;
      n_inj += (inject_pulse[0] === 1'b1);
      if (cyc_cnt == 30000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // One single word: address phase, then data phase
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, 24'h0, a, w};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   // Edges on one sense bit; the model follows half A overcurrent and frames
   task automatic ev(input int b, input int n);
      repeat (n) begin
         sense[b] <= 1'b1;
         cyc(4);
         sense[b] <= 1'b0;
         cyc(4);
         m_cnt = (b == 6 && m_cnt < 15) ? m_cnt + 1 : (b == 17 && m_ev == 0 && m_cnt > 0) ? m_cnt - 1 : m_cnt;
         m_ev = (b == 6) ? 1 : (b == 17) ? 0 : m_ev;
      end
   endtask
   // Controller cycles the reset pin
   task automatic rstc();
      rst_req <= 1'b1;
      cyc(6);
      `CHK(fault_pin, 1'b1)
      rst_req <= 1'b0;
      m_cnt = 0;
      cyc(HOLD + 8);
   endtask
   initial begin
      int s;
      logic sup;
      cyc(5);
      hresetn <= 1'b1;
      rst_req <= 1'b1;
      sense.short_gnd <= 1'b1;
      cyc(2500);
      ahb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rd[13:12], 2'b01)
      `CHK({fault_pin, hb_enable}, 5'h00)
      {sense.short_gnd, rst_req} <= 2'b00;
      rd = 32'h0;
      sup = 1'b0;
      cyc(1);
      while (rd[13:12] !== 2'b10) begin
         ahb(1'b0, ADDR_STATUS, 32'h0);
         sup |= (rd[13:12] === 2'b11);
      end
      cyc(4);
      `CHK({sup, fault_pin, hb_enable}, 6'h3f)
      rstc();
      ahb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rd[13:12], 2'b10)
      $display("test startup done");
      for (s = 0; s < 16; s++) begin
         ahb(1'b1, ADDR_CONTROL, 32'(s));
         ahb(1'b0, ADDR_CONTROL, 32'h0);
         `CHK(rd[3:0], 4'(s))
         `CHK(oc_threshold, (s < 8) ? 2'(s) : OC_MIN_THRESHOLD)
         `CHK(oc_latched, 1'(s >= 4 && s < 8))
         `CHK({hresp, hreadyout}, 2'b01)
      end
      ahb(1'b1, 8'h0c, $random(seed));
      ahb(1'b0, 8'h0c, 32'h0);
      `CHK(rd, 32'h0)
      ahb(1'b1, ADDR_CONTROL, 32'h0);
      $display("test select done");
      sense.temp_warn <= 1'b1;
      cyc(6);
      `CHK({fault_pin, warn_pin}, 2'b10)
      `CHK(vol_down, 1'b1)
      sense.temp_shut <= 1'b1;
      cyc(6);
      `CHK({fault_pin, warn_pin, hb_enable}, 6'h00)
      {sense.temp_shut, sense.temp_warn} <= 2'b00;
      cyc(16);
      `CHK({fault_pin, warn_pin, hb_enable}, 6'h10)
      rstc();
      `CHK({fault_pin, warn_pin, hb_enable}, 6'h3f)
      sense.undervolt <= 1'b1;
      cyc(6);
      `CHK({fault_pin, warn_pin, hb_enable}, 6'h10)
      sense.undervolt <= 1'b0;
      cyc(6);
      `CHK({fault_pin, hb_enable}, 5'h1f)
      sense.boot_uv <= 4'h4;
      cyc(6);
      `CHK({fault_pin, hb_enable}, 5'h1b)
      sense.boot_uv <= 4'h0;
      $display("test thermal done");
      ev(6, 1);
      `CHK(flip_state, 4'h1)
      ev(17, 1);
      `CHK(flip_state, 4'h0)
      for (s = 0; s < 2; s++) begin
         ahb(1'b0, ADDR_COUNT, 32'h0);
         `CHK(rd[3:0], 4'(m_cnt))
         ev(17, 2);
      end
      sense.clip[0] <= 1'b1;
      cyc(5);
      `CHK(warn_pin, 1'b0)
      n_inj = 0;
      ev(17, 8);
      `CHK(n_inj, 2)
      sense.clip[0] <= 1'b0;
      cyc(16);
      `CHK(warn_pin, 1'b1)
      ev(6, 15);
      ahb(1'b0, ADDR_COUNT, 32'h0);
      `CHK({rd[3:0], fault_pin, hb_enable}, {4'(m_cnt), 5'h0c})
      rstc();
      mode_pins <= 2'b10;
      ev(9, 15);
      `CHK({fault_pin, hb_enable}, 5'h00)
      rstc();
      mode_pins <= 2'b00;
      ahb(1'b1, ADDR_CONTROL, 32'h4);
      ev(8, 1);
      `CHK({fault_pin, hb_enable}, 5'h03)
      rstc();
      ahb(1'b1, ADDR_CONTROL, 32'h0);
      mode_pins <= 2'b11;
      ev(4, 15);
      `CHK({fault_pin, hb_enable}, 5'h1f)
      mode_pins <= 2'b00;
      ev(4, 15);
      `CHK({fault_pin, hb_enable}, 5'h0c)
      rstc();
      $display("test overload done");
      {mode_pins, hresetn} <= 3'b110;
      cyc(3);
      hresetn <= 1'b1;
      cyc(10);
      ahb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rd[13:12], 2'b10)
      $display("test single ended done");
      report_and_stop();
   end
endmodule

// ---- verilog/amp_protect.sv ----
// Protection supervisor: fault reporting, shutdown mapping, current limit, checks
`timescale 1ns/1ps
// Notes on behaviour
// (RULE1) Both status outputs active-low open-drain
// (RULE2) Any shutdown fault pulls fault low
// (RULE3) Warning output low while temperature warning
// (RULE4) Two outputs encode fault and warning state
// (RULE5) Reset pin low forces fault released
// (RULE6) Controller lowers volume on warning
// (RULE7) Fault puts outputs off, fault low
// (RULE8) Undervoltage recovers by itself
// (RULE9) Pair shutdown, parallel mode shuts all
// (RULE10) Bootstrap undervoltage disables own half only
// (RULE11) Cycle limit or latched overcurrent mode
// (RULE12) Select picks mode and threshold
// (RULE13) Invalid select gives minimum threshold
// (RULE14) Overcurrent flips half, cleared next frame
// (RULE15) Overload counter up/down, max latches off
// (RULE16) Latched mode shuts on first event
// (RULE17) Inject pulse every fourth frame
// (RULE18) Clipping shown as self-clearing low pulses
// (RULE19) DC imbalance counts, off in single-ended
// (RULE20) Startup check ground then supply
// (RULE21) Check holds fault, ignores reset, once
// (RULE22) Check skipped in single-ended mode
// (RULE23) Warning level, latched thermal shutdown
// (RULE24) Reset release at least 4 ms after fault
// (RULE25) Counter width and max are constants
module amp_protect (
   // Bus clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Device pins and analog sense
   input wire logic reset_pin_n,
   input wire logic [1:0] mode_pins,
   input wire amp_protect_pkg::sense_type sense,
   // Open-drain status pins
   output logic fault_n_out,
   output logic fault_n_oe,
   output logic clip_temp_warn_n,
   output logic clip_temp_warn_oe,
   // Power stage control
   output logic [3:0] hb_enable,
   output logic [3:0] flip_state,
   output logic [3:0] inject_pulse,
   output logic [1:0] oc_threshold,
   output logic oc_latched
);
   import amp_protect_pkg::*;

   // Synchroniser stages; the first stage feeds only the second
   sense_type sense_m;
   sense_type sense_s;
   sense_type sense_d;
   logic [1:0] mode_m;
   logic [1:0] mode_s;
   logic rst_m;
   logic rst_s;

   // Bus state
   logic wr_pend;
   logic [7:0] addr_q;
   logic [3:0] oc_sel;

   // Protection state
   logic thermal;
   logic [3:0] overload;
   logic [OL_WIDTH-1:0] ol_cnt [4];
   logic [3:0] seen;
   logic [1:0] frame_cnt;
   logic [4:0] clip_cnt;
   logic [11:0] step_cnt;
   check_state_type chk;
   check_state_type next_chk;

   // All comparator levels cross into hclk together
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sense_m <= '0;
         sense_s <= '0;
         sense_d <= '0;
         mode_m <= 2'h0;
         mode_s <= 2'h0;
         rst_m <= 1'b0;
         rst_s <= 1'b0;
      end else begin
         sense_m <= sense;
         sense_s <= sense_m;
         sense_d <= sense_s;
         mode_m <= mode_pins;
         mode_s <= mode_m;
         rst_m <= reset_pin_n;
         rst_s <= rst_m;
      end
   end

   // Edges are taken between the second and third stage
   // A frame edge lasts one cycle, so it also serves as the frame strobe
   wire frame_tick = sense_s.frame & ~sense_d.frame;
   wire [3:0] oc_rise = sense_s.overcurrent & ~sense_d.overcurrent;
   wire [1:0] dc_rise = sense_s.dc_imbalance & ~sense_d.dc_imbalance;
   wire [1:0] clip_rise = sense_s.clip & ~sense_d.clip;

   // Mode decode; mixed mode is handled like single-ended
   wire mode_parallel = (mode_s == PARALLEL_BRIDGE_MODE);
   wire mode_bridge_like = (mode_s == BRIDGE_TIED_MODE) | mode_parallel;
   wire dc_enable = mode_bridge_like; // RULE19

   // Overcurrent select decode
   wire sel_latched = (oc_sel >= OC_LATCHED_FIRST) & (oc_sel <= OC_VALID_LAST); // RULE11 RULE12
   wire sel_valid = (oc_sel <= OC_VALID_LAST);
   wire [1:0] next_threshold = sel_valid ? oc_sel[1:0] : OC_MIN_THRESHOLD; // RULE12 RULE13

   // Latches clear while reset pin is low, but not during the check
   wire check_done = (chk == CHK_DONE);
   wire clear_latch = ~rst_s & check_done; // RULE21

   // AHB-Lite decode; zero wait states, always OKAY
   wire accept = hsel & hready & htrans[1];
   wire [7:0] a_now = haddr[7:0];
   wire wr_control = wr_pend & (addr_q == ADDR_CONTROL);
   wire [3:0] next_oc_sel = wr_control ? hwdata[OC_SEL_LSB +: 4] : oc_sel;

   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         addr_q <= 8'h00;
      end else if (hready) begin
         wr_pend <= accept & hwrite;
         addr_q <= a_now;
      end
   end

   // Control register; takes write data in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         oc_sel <= OC_SELECT_RESET;
      end else begin
         oc_sel <= next_oc_sel;
      end
   end

   // Threshold and mode drive the analog trip level from flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         oc_threshold <= OC_MIN_THRESHOLD;
         oc_latched <= 1'b0;
      end else begin
         oc_threshold <= next_threshold; // RULE12
         oc_latched <= sel_latched; // RULE11
      end
   end

   // Startup pin short check, run once after power-on reset
   always_comb begin
      next_chk = chk;
      unique case (chk)
         CHK_START: begin
            // Wait for the mode pins to settle through the synchroniser;
            // the reset value of the mode stages reads as bridge-tied
            if (step_cnt != 12'(MODE_SETTLE_CYC)) begin
               next_chk = CHK_START;
            end else if (!mode_bridge_like) begin
               next_chk = CHK_DONE; // RULE22
            end else begin
               next_chk = CHK_GROUND; // RULE20
            end
         end
         CHK_GROUND: begin
            // A short keeps restarting the step, so the stage stays off
            if ((step_cnt == 12'(CHECK_STEP_CYC - 1)) && !sense_s.short_gnd) begin
               next_chk = CHK_SUPPLY; // RULE20
            end
         end
         CHK_SUPPLY: begin
            if ((step_cnt == 12'(CHECK_STEP_CYC - 1)) && !sense_s.short_supply) begin
               next_chk = CHK_DONE; // RULE20
            end
         end
         CHK_DONE: begin
            // Reset pin activity never restarts the check
            next_chk = CHK_DONE; // RULE21
         end
      endcase
   end

   // Check state and step timer
   // The same timer measures the settle wait in the start state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chk <= CHK_START;
         step_cnt <= 12'h000;
      end else begin
         chk <= next_chk;
         if (next_chk != chk) begin
            step_cnt <= 12'h000;
         end else if (step_cnt == 12'(CHECK_STEP_CYC - 1)) begin
            step_cnt <= 12'h000;
         end else begin
            step_cnt <= step_cnt + 12'h001;
         end
      end
   end

   // Thermal shutdown latch; a hot die keeps it set through reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         thermal <= 1'b0;
      end else if (sense_s.temp_shut) begin
         thermal <= 1'b1; // RULE23
      end else if (clear_latch) begin
         thermal <= 1'b0; // RULE23
      end
   end

   // Per half-bridge current limit, overload counter and latch
   genvar h;
   generate
      for (h = 0; h < 4; h = h + 1) begin : g_half
         // Events that load the counter; latched mode shuts instead
         wire dc_ev = dc_rise[h/2] & dc_enable;
         wire ol_ev = (oc_rise[h] & ~sel_latched) | dc_ev; // RULE15 RULE19
         wire at_max = (ol_cnt[h] == OL_MAX);

         // Up on each event, down on a quiet frame, floor at zero
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               ol_cnt[h] <= '0;
            end else if (clear_latch) begin
               ol_cnt[h] <= '0;
            end else if (ol_ev) begin
               if (!at_max) begin
                  ol_cnt[h] <= ol_cnt[h] + 1'b1; // RULE15 RULE25
               end
            end else if (frame_tick && !seen[h] && (ol_cnt[h] != '0)) begin
               ol_cnt[h] <= ol_cnt[h] - 1'b1; // RULE15 RULE25
            end
         end

         // Marks a frame that had an event; a tick with an event starts a marked frame
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               seen[h] <= 1'b0;
            end else if (frame_tick) begin
               seen[h] <= ol_ev;
            end else if (ol_ev) begin
               seen[h] <= 1'b1;
            end
         end

         // State flip lasts until the next frame starts; a new event wins
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               flip_state[h] <= 1'b0;
            end else if (oc_rise[h] && !sel_latched) begin
               flip_state[h] <= 1'b1; // RULE14
            end else if (frame_tick) begin
               flip_state[h] <= 1'b0; // RULE14
            end
         end

         // Overload shutdown holds until the reset pin is cycled
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               overload[h] <= 1'b0;
            end else if (at_max || (oc_rise[h] && sel_latched)) begin
               overload[h] <= 1'b1; // RULE15 RULE16
            end else if (clear_latch) begin
               overload[h] <= 1'b0;
            end
         end
      end
   endgenerate

   // Shutdown mapping: pairs, or all four in parallel mode
   wire ch_ab = overload[0] | overload[1];
   wire ch_cd = overload[2] | overload[3];
   wire [3:0] group_off = mode_parallel ? {4{ch_ab | ch_cd}} : {{2{ch_cd}}, {2{ch_ab}}}; // RULE9
   // Undervoltage is unlatched, so switching resumes when supply returns
   wire global_off = thermal | sense_s.undervolt | ~check_done | ~rst_s; // RULE7 RULE8 RULE20 RULE23
   // Bootstrap undervoltage masks only its own half, no fault
   wire [3:0] next_enable = ~({4{global_off}} | group_off | sense_s.boot_uv); // RULE10

   // Fault: check in progress, or any shutdown fault outside reset
   // Reset pin low releases the pin only once the check has passed
   wire shut_fault = thermal | sense_s.undervolt | (|overload);
   wire fault_active = ~check_done | (rst_s & shut_fault); // RULE2 RULE5 RULE21

   // Clipping or limiting per output channel
   wire [1:0] sat_ch = sense_s.clip | {flip_state[3] | flip_state[2], flip_state[1] | flip_state[0]};
   wire [3:0] sat_half = {{2{sat_ch[1]}}, {2{sat_ch[0]}}};

   // Frame counter picks every fourth frame for injection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_cnt <= 2'h0;
      end else if (frame_tick) begin
         frame_cnt <= frame_cnt + 2'h1;
      end
   end

   // Clip pulse stretcher; a clip edge restarts the minimum width
   // The width floor keeps short clips visible to a slow controller
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clip_cnt <= 5'h00;
      end else if (|clip_rise) begin
         clip_cnt <= 5'(CLIP_PULSE_CYC); // RULE18
      end else if (clip_cnt != 5'h00) begin
         clip_cnt <= clip_cnt - 5'h01; // RULE18
      end
   end

   // Warning pin: temperature level or clip pulse, cleared by itself
   wire clip_low = (clip_cnt != 5'h00) | (|sense_s.clip);
   wire warn_active = sense_s.temp_warn | clip_low; // RULE3 RULE18 RULE23

   // Output registers; open-drain pins drive low only when enabled
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hb_enable <= 4'h0;
         inject_pulse <= 4'h0;
         fault_n_oe <= 1'b0;
         clip_temp_warn_oe <= 1'b0;
      end else begin
         hb_enable <= next_enable; // RULE7 RULE9
         inject_pulse <= {4{frame_tick & (frame_cnt == INJECT_FRAME)}} & sat_half & next_enable; // RULE17
         fault_n_oe <= fault_active; // RULE1 RULE4
         clip_temp_warn_oe <= warn_active; // RULE1 RULE4
      end
   end

   // Open-drain data is always low; the enable carries the level
   assign fault_n_out = 1'b0; // RULE1
   assign clip_temp_warn_n = 1'b0; // RULE1

   // Read views of the block state
   wire [31:0] status_word = {15'h0000, oc_threshold, oc_latched, chk, hb_enable, overload,
      sense_s.undervolt, thermal, warn_active, fault_active};
   wire [31:0] count_word = {16'h0000, ol_cnt[3], ol_cnt[2], ol_cnt[1], ol_cnt[0]};
   wire [31:0] control_word = {28'h0000000, next_oc_sel};

   // Read mux; unmapped addresses read zero
   wire [31:0] read_word = (a_now == ADDR_CONTROL) ? control_word :
      (a_now == ADDR_STATUS) ? status_word :
      (a_now == ADDR_COUNT) ? count_word : 32'h00000000;

   // Read data is loaded in the address phase so it stands in the data phase
   // Status is thus a snapshot one cycle older than the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (accept && !hwrite) begin
         hrdata <= read_word;
      end
   end

   // No wait states and no error answers
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
endmodule

// ---- verilog/amp_protect_pkg.sv ----
// Constants, codes and carrier types for the power stage protection supervisor
package amp_protect_pkg;
   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_COUNT = 8'h08;
   // Control field: overcurrent select code, bits 3:0
   localparam int OC_SEL_LSB = 0;
   localparam logic [3:0] OC_SELECT_RESET = 4'h0;
   // Select codes 0..3 are cycle limiting, 4..7 latched, the rest invalid
   localparam logic [3:0] OC_LATCHED_FIRST = 4'h4;
   localparam logic [3:0] OC_VALID_LAST = 4'h7;
   localparam logic [1:0] OC_MIN_THRESHOLD = 2'h3;
   // Status field positions
   localparam int ST_FAULT = 0;
   localparam int ST_WARN = 1;
   localparam int ST_THERMAL = 2;
   localparam int ST_UNDERVOLT = 3;
   localparam int ST_OVERLOAD_LSB = 4;
   localparam int ST_ENABLE_LSB = 8;
   localparam int ST_CHECK_LSB = 12;
   localparam int ST_LATCHED = 14;
   localparam int ST_THRESH_LSB = 15;
   // Overload counter
   localparam int OL_WIDTH = 4;
   localparam logic [OL_WIDTH-1:0] OL_MAX = 4'hf;
   // Timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int CLIP_PULSE_NS = 500;
   localparam int CLIP_PULSE_CYC = CLIP_PULSE_NS / CLK_PERIOD_NS;
   localparam int CHECK_STEP_US = 100;
   localparam int CHECK_STEP_CYC = (CHECK_STEP_US * 1000) / CLK_PERIOD_NS;
   // Cycles before the synchronised mode pins hold the real setting
   localparam int MODE_SETTLE_CYC = 2;
   // Every fourth frame carries an injected pulse on each saturating, enabled half
   localparam logic [1:0] INJECT_FRAME = 2'h3;
   // Output configuration pin codes
   typedef enum logic [1:0] {
      BRIDGE_TIED_MODE = 2'b00,
      MIXED_MODE = 2'b01,
      PARALLEL_BRIDGE_MODE = 2'b10,
      SINGLE_ENDED_MODE = 2'b11
   } mode_type;
   // Pin short check sequence, Gray coded
   typedef enum logic [1:0] {
      CHK_START = 2'b00,
      CHK_GROUND = 2'b01,
      CHK_SUPPLY = 2'b11,
      CHK_DONE = 2'b10
   } check_state_type;
   // Analog comparator levels, all asynchronous to hclk
   typedef struct packed {
      logic frame;
      logic temp_warn;
      logic temp_shut;
      logic undervolt;
      logic [3:0] boot_uv;
      logic [3:0] overcurrent;
      logic [1:0] dc_imbalance;
      logic [1:0] clip;
      logic short_gnd;
      logic short_supply;
   } sense_type;
endpackage
